// ===== pkg/charge_port_pkg.sv
`default_nettype none
package charge_port_pkg;
  // clock and dwell times
  localparam int CLK_MHZ = 100;
  localparam int ASSERT_DWELL_MS = 200;
  localparam int RELEASE_DWELL_S = 3;
  localparam int ASSERT_DWELL_CYCLES = ASSERT_DWELL_MS * CLK_MHZ * 1000;
  localparam int RELEASE_DWELL_CYCLES = RELEASE_DWELL_S * CLK_MHZ * 1000000;
  localparam int DWELL_WIDTH = 32;

  // apb map
  localparam int ADDR_WIDTH = 8;
  localparam logic [7:0] DISCHARGE_LEN_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [15:0] DISCHARGE_LEN_RESET = 16'h0400;

  // status register fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_LIMIT_LSB = 4;
  localparam int STAT_SWITCH_BIT = 8;
  localparam int STAT_DISCHARGE_BIT = 9;
  localparam int STAT_LOAD_BIT = 10;
  localparam int STAT_HOLD_BIT = 11;

  // control pin codes {mode_select_a, mode_select_b, mode_select_c}
  localparam logic [2:0] PINS_DISCHARGE = 3'h0;
  localparam logic [2:0] PINS_AUTO_WAKE = 3'h1;
  localparam logic [2:0] PINS_PORT_A = 3'h2;
  localparam logic [2:0] PINS_AUTO_SENSE = 3'h3;
  localparam logic [2:0] PINS_SHORTED = 3'h4;
  localparam logic [2:0] PINS_DIVIDER = 3'h5;
  localparam logic [2:0] PINS_PORT_B = 3'h6;
  localparam logic [2:0] PINS_DATA_CHARGE = 3'h7;

  typedef enum logic [3:0] {
    MODE_DISCHARGE,
    MODE_DEDICATED_CHARGE_AUTOMATIC,
    MODE_AUTO_POWER_WAKE,
    MODE_AUTO_LOAD_SENSE,
    MODE_DEDICATED_CHARGE_SHORTED,
    MODE_FIXED_DIVIDER_SCHEME,
    MODE_STANDARD_PORT_PLAIN,
    MODE_STANDARD_PORT_NO_DISCHARGE,
    MODE_DATA_CHARGE
  } mode_t;

  typedef enum logic [1:0] {
    LIMIT_NONE,
    LIMIT_LOW,
    LIMIT_HIGH,
    LIMIT_POWER_WAKE
  } limit_t;
endpackage : charge_port_pkg
`default_nettype wire

// ===== rtl/dwell_timer.sv
`timescale 1ns/1ns
`default_nettype none
module dwell_timer #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic clear,
  input wire logic cond,
  input wire logic [WIDTH-1:0] limit,
  // result
  output logic done
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // done in the limit-th consecutive cycle of cond
  assign done = cond && !clear && (s_reg.count >= limit - WIDTH'(1));

  always_comb
  begin
    s_next = s_reg;
    if (clear || !cond)
    begin
      s_next.count = '0;
    end
    else if (!done)
    begin
      s_next.count = s_reg.count + WIDTH'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end
endmodule : dwell_timer
`default_nettype wire

// ===== rtl/charge_port_mode_decoder.sv
// Overview of operation
// - data switches close only in SDP or CDP modes with enable high
// - switches stay closed in CDP during its handshake
// - switches open on enable low, pins 000, or any DCP mode
// - current limiting on the power path never opens the switches
// - switches held open for the whole output discharge
// - mode follows control pins except while an LS/FS HID is detected
// - pins 001/011 give automatic DCP, isolated; select 0 means no load status
// - pins 001 with select 1 run load detection, status low on load
// - code 0011 switches limit between power-wake and high by load detection
// - code 0011 judges load with the power-wake thresholds
// - code 0111 uses high limit and non-power-wake thresholds
// - pins 010/110 give plain SDP, limit by select, status inactive
// - pins 100 fix the shorted DCP scheme, limit by select
// - pins 101 fix the divider DCP scheme, limit by select
// - 1110 is SDP low limit, 1111 CDP high; no discharge between them
// - CDP keeps data connected; status on load or primary detection
// - pins 000 discharge the output, no limit, status inactive
// - status asserts after 200 ms above, releases after 3 s below
// - reset holds discharge state, then pins select the mode
`timescale 1ns/1ns
`default_nettype none
module charge_port_mode_decoder
#(
  parameter int ASSERT_CYCLES = charge_port_pkg::ASSERT_DWELL_CYCLES,
  parameter int RELEASE_CYCLES = charge_port_pkg::RELEASE_DWELL_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control pins
  input wire logic mode_select_a,
  input wire logic mode_select_b,
  input wire logic mode_select_c,
  input wire logic limit_select,
  input wire logic enable,
  // sense flags from the analog side
  input wire logic hid_detected,
  input wire logic load_above,
  input wire logic load_below,
  input wire logic wake_load_above,
  input wire logic wake_load_below,
  input wire logic primary_detect,
  // port controls
  output logic data_switch_on,
  output logic discharge_on,
  output charge_port_pkg::limit_t current_limit,
  output logic load_status_n,
  output charge_port_pkg::mode_t charge_mode,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [charge_port_pkg::ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import charge_port_pkg::*;

  typedef struct packed {
    mode_t mode;
    limit_t limit;
    logic hold;
    logic [15:0] dchg_len;
    logic [15:0] dchg_cnt;
    logic data_sw;
    logic dchg;
    logic load;
    logic [31:0] rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic [2:0] pins;
  mode_t dec_mode;
  limit_t dec_limit;
  logic detect_mode;
  logic wake_mode;
  logic above_sel;
  logic below_sel;
  logic assert_done;
  logic release_done;
  logic dchg_trigger;
  logic apb_access;
  logic addr_ok;
  logic [31:0] status_word;

  assign pins = {mode_select_a, mode_select_b, mode_select_c};

  function automatic logic is_data(input mode_t m);
    return (m == MODE_STANDARD_PORT_PLAIN) || (m == MODE_STANDARD_PORT_NO_DISCHARGE) ||
      (m == MODE_DATA_CHARGE);
  endfunction : is_data

  function automatic logic is_auto(input mode_t m);
    return (m == MODE_DEDICATED_CHARGE_AUTOMATIC) || (m == MODE_AUTO_POWER_WAKE) ||
      (m == MODE_AUTO_LOAD_SENSE);
  endfunction : is_auto

  // pin decode
  always_comb
  begin
    dec_mode = MODE_DISCHARGE;
    dec_limit = LIMIT_NONE;
    if (pins == PINS_DISCHARGE)
    begin
      dec_mode = MODE_DISCHARGE;
      dec_limit = LIMIT_NONE;
    end
    else if (pins == PINS_AUTO_WAKE || pins == PINS_AUTO_SENSE)
    begin
      dec_limit = LIMIT_HIGH;
      if (!limit_select)
      begin
        dec_mode = MODE_DEDICATED_CHARGE_AUTOMATIC;
      end
      else if (pins == PINS_AUTO_WAKE)
      begin
        dec_mode = MODE_AUTO_POWER_WAKE;
        dec_limit = LIMIT_POWER_WAKE;
      end
      else
      begin
        dec_mode = MODE_AUTO_LOAD_SENSE;
      end
    end
    else if (pins == PINS_PORT_A || pins == PINS_PORT_B)
    begin
      dec_mode = MODE_STANDARD_PORT_PLAIN;
      dec_limit = limit_select ? LIMIT_HIGH : LIMIT_LOW;
    end
    else if (pins == PINS_SHORTED)
    begin
      dec_mode = MODE_DEDICATED_CHARGE_SHORTED;
      dec_limit = limit_select ? LIMIT_HIGH : LIMIT_LOW;
    end
    else if (pins == PINS_DIVIDER)
    begin
      dec_mode = MODE_FIXED_DIVIDER_SCHEME;
      dec_limit = limit_select ? LIMIT_HIGH : LIMIT_LOW;
    end
    else
    begin
      dec_mode = limit_select ? MODE_DATA_CHARGE : MODE_STANDARD_PORT_NO_DISCHARGE;
      dec_limit = limit_select ? LIMIT_HIGH : LIMIT_LOW;
    end
  end

  // load sensing runs off the committed mode
  assign detect_mode = (s_reg.mode == MODE_AUTO_POWER_WAKE) ||
    (s_reg.mode == MODE_AUTO_LOAD_SENSE) || (s_reg.mode == MODE_DATA_CHARGE);
  assign wake_mode = (s_reg.mode == MODE_AUTO_POWER_WAKE);
  assign above_sel = wake_mode ? wake_load_above : load_above;
  assign below_sel = wake_mode ? wake_load_below : load_below;

  dwell_timer #(
    .WIDTH(DWELL_WIDTH)
  ) assert_timer (
    .clk(clk),
    .arst_n(arst_n),
    .clear(!detect_mode || s_reg.load),
    .cond(above_sel),
    .limit(DWELL_WIDTH'(ASSERT_CYCLES)),
    .done(assert_done)
  );

  dwell_timer #(
    .WIDTH(DWELL_WIDTH)
  ) release_timer (
    .clk(clk),
    .arst_n(arst_n),
    .clear(!detect_mode || !s_reg.load),
    .cond(below_sel),
    .limit(DWELL_WIDTH'(RELEASE_CYCLES)),
    .done(release_done)
  );

  // class change between data and automatic charging renegotiates by discharge
  // taken from the decode, not s_next, so the state process sees no loop through itself
  assign dchg_trigger = !hid_detected && ((is_data(s_reg.mode) && is_auto(dec_mode)) ||
    (is_auto(s_reg.mode) && is_data(dec_mode)));

  assign apb_access = psel && penable;
  assign addr_ok = (paddr == DISCHARGE_LEN_ADDR) || (paddr == STATUS_ADDR);

  always_comb
  begin
    status_word = '0;
    status_word[STAT_MODE_LSB +: 4] = s_reg.mode;
    status_word[STAT_LIMIT_LSB +: 2] = s_reg.limit;
    status_word[STAT_SWITCH_BIT] = s_reg.data_sw;
    status_word[STAT_DISCHARGE_BIT] = s_reg.dchg;
    status_word[STAT_LOAD_BIT] = s_reg.load;
    status_word[STAT_HOLD_BIT] = s_reg.hold;
  end

  always_comb
  begin
    s_next = s_reg;
    s_next.hold = hid_detected;
    // mode follows pins unless a low/full speed hid is attached
    if (!hid_detected)
    begin
      s_next.mode = dec_mode;
      s_next.limit = dec_limit;
    end
    // load status; set wins over release
    if (!((s_next.mode == MODE_AUTO_POWER_WAKE) || (s_next.mode == MODE_AUTO_LOAD_SENSE) ||
      (s_next.mode == MODE_DATA_CHARGE)) || !detect_mode)
    begin
      s_next.load = 1'b0;
    end
    else if (assert_done || (s_reg.mode == MODE_DATA_CHARGE && primary_detect))
    begin
      s_next.load = 1'b1;
    end
    else if (release_done)
    begin
      s_next.load = 1'b0;
    end
    // power-wake: high limit only while a load is recognised
    if (s_next.mode == MODE_AUTO_POWER_WAKE)
    begin
      s_next.limit = s_next.load ? LIMIT_HIGH : LIMIT_POWER_WAKE;
    end
    // discharge timer; no-discharge-to-charge swap of 1110/1111 never triggers
    if (dchg_trigger)
    begin
      s_next.dchg_cnt = s_reg.dchg_len;
    end
    else if (s_reg.dchg_cnt != 16'h0000)
    begin
      s_next.dchg_cnt = s_reg.dchg_cnt - 16'h0001;
    end
    s_next.dchg = (s_next.mode == MODE_DISCHARGE) || (s_next.dchg_cnt != 16'h0000);
    // no current-limit term here, so limiting never isolates the data lines
    s_next.data_sw = enable && is_data(s_next.mode) && !s_next.dchg;
    // apb: read data captured in setup, write at access
    if (psel && !penable)
    begin
      if (paddr == DISCHARGE_LEN_ADDR)
      begin
        s_next.rdata = {16'h0000, s_reg.dchg_len};
      end
      else if (paddr == STATUS_ADDR)
      begin
        s_next.rdata = status_word;
      end
      else
      begin
        s_next.rdata = 32'h0000_0000;
      end
    end
    if (apb_access && pwrite && paddr == DISCHARGE_LEN_ADDR)
    begin
      s_next.dchg_len = pwdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_reg.mode <= MODE_DISCHARGE;
      s_reg.limit <= LIMIT_NONE;
      s_reg.hold <= 1'b0;
      s_reg.dchg_len <= DISCHARGE_LEN_RESET;
      s_reg.dchg_cnt <= 16'h0000;
      s_reg.data_sw <= 1'b0;
      s_reg.dchg <= 1'b1;
      s_reg.load <= 1'b0;
      s_reg.rdata <= 32'h0000_0000;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign data_switch_on = s_reg.data_sw;
  assign discharge_on = s_reg.dchg;
  assign current_limit = s_reg.limit;
  assign load_status_n = !s_reg.load;
  assign charge_mode = s_reg.mode;
  assign prdata = s_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = apb_access && !addr_ok;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_switch_needs_enable: assert property (
    data_switch_on |-> $past(enable) && is_data(charge_mode))
    else $error("data switch closed without enable or data mode");

  a_switch_cdp_closed: assert property (
    (charge_mode == MODE_DATA_CHARGE && $past(charge_mode) == MODE_DATA_CHARGE &&
      $past(enable) && !discharge_on) |-> data_switch_on)
    else $error("switch opened during charging downstream mode");

  a_switch_dcp_open: assert property (
    (is_auto(charge_mode) || charge_mode == MODE_DISCHARGE ||
      charge_mode == MODE_DEDICATED_CHARGE_SHORTED ||
      charge_mode == MODE_FIXED_DIVIDER_SCHEME) |-> !data_switch_on)
    else $error("switch closed in dedicated or discharge mode");

  a_switch_dchg_open: assert property (
    discharge_on |-> !data_switch_on)
    else $error("switch closed during discharge");

  a_pins_followed: assert property (
    !hid_detected |=> charge_mode == $past(dec_mode))
    else $error("mode did not follow control pins");

  a_hid_freezes: assert property (
    hid_detected |=> charge_mode == $past(charge_mode))
    else $error("mode changed while hid detected");

  a_wake_limit: assert property (
    charge_mode == MODE_AUTO_POWER_WAKE |->
      current_limit == (load_status_n ? LIMIT_POWER_WAKE : LIMIT_HIGH))
    else $error("power wake limit does not track load");

  a_no_dchg_swap: assert property (
    (charge_mode == MODE_STANDARD_PORT_NO_DISCHARGE && !discharge_on && !hid_detected &&
      dec_mode == MODE_DATA_CHARGE) |=> !discharge_on && charge_mode == MODE_DATA_CHARGE)
    else $error("discharge on swap between no-discharge port and charge mode");

  a_status_detect: assert property (
    !load_status_n |-> (charge_mode == MODE_AUTO_POWER_WAKE ||
      charge_mode == MODE_AUTO_LOAD_SENSE || charge_mode == MODE_DATA_CHARGE))
    else $error("status asserted outside load detect modes");

  a_primary_sets: assert property (
    (charge_mode == MODE_DATA_CHARGE && primary_detect && !hid_detected &&
      dec_mode == MODE_DATA_CHARGE) |=> !load_status_n)
    else $error("primary detection did not assert status");

  a_pins_discharge: assert property (
    (pins == PINS_DISCHARGE && !hid_detected) |=> discharge_on && current_limit == LIMIT_NONE
      && load_status_n)
    else $error("pins 000 did not discharge");

  c_cdp_status: cover property (charge_mode == MODE_DATA_CHARGE && !load_status_n);
  c_auto_dchg: cover property (charge_mode == MODE_DEDICATED_CHARGE_AUTOMATIC && discharge_on);
  c_hid_hold: cover property (hid_detected ##1 hid_detected && dec_mode != charge_mode);
  c_wake_high: cover property (charge_mode == MODE_AUTO_POWER_WAKE && !load_status_n);
endmodule : charge_port_mode_decoder
`default_nettype wire

// ===== dv/portable_device.sv
`timescale 1ns/1ns
`default_nettype none
module portable_device #(
  parameter int LOW_LIMIT_MA = 500,
  parameter int WAKE_ABOVE_MA = 1000,
  parameter int WAKE_BELOW_MA = 100
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // commands from the bench
  input wire logic [15:0] draw_ma,
  input wire logic hid_attach,
  input wire logic primary_req,
  // port side seen by the device
  input wire logic data_switch_on,
  // sense flags
  output logic hid_detected,
  output logic load_above,
  output logic load_below,
  output logic wake_load_above,
  output logic wake_load_below,
  output logic primary_detect
);
  // all flags launched just after an edge, so the block samples them cleanly
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {hid_detected, load_above, load_below} <= 3'h0;
      {wake_load_above, wake_load_below, primary_detect} <= 3'h0;
    end
    else
    begin
      load_above <= int'(draw_ma) > LOW_LIMIT_MA + 60;
      load_below <= int'(draw_ma) < LOW_LIMIT_MA + 10;
      wake_load_above <= int'(draw_ma) > WAKE_ABOVE_MA;
      wake_load_below <= int'(draw_ma) < WAKE_BELOW_MA;
      hid_detected <= hid_attach;
      // detection needs the data lines, so only with the switch closed
      primary_detect <= primary_req & data_switch_on;
    end
  end
endmodule : portable_device
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import charge_port_pkg::*;
  localparam int DLEN = 8;
  localparam int LO_MA = 500;
  localparam int WAKE_MA = 1000;
  // release point above the lowest draw, so a load carried into power wake releases
  localparam int WAKE_LO_MA = 150;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic mode_select_a = 1'h0, mode_select_b = 1'h0, mode_select_c = 1'h0;
  logic limit_select = 1'h0, enable = 1'h0, hid_attach = 1'h0, primary_req = 1'h0;
  logic [15:0] draw_ma = 16'h0064;
  logic hid_detected, load_above, load_below, wake_load_above, wake_load_below;
  logic primary_detect, data_switch_on, discharge_on, load_status_n, pready, pslverr;
  limit_t current_limit;
  mode_t charge_mode;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  int fails = 0, n_checks = 0, seed = 32'h61C72F9F;
  int draws[$] = '{100, 1200};
  int mt[16] = '{0, 0, 1, 2, 6, 6, 1, 3, 4, 4, 5, 5, 6, 6, 7, 8};
  int lt[16] = '{0, 0, 2, 3, 1, 2, 2, 2, 1, 2, 1, 2, 1, 2, 1, 2};

  always #5 clk = ~clk;

  charge_port_mode_decoder #(.ASSERT_CYCLES(20), .RELEASE_CYCLES(30)) i_dut (
    .clk, .arst_n, .mode_select_a, .mode_select_b, .mode_select_c, .limit_select,
    .enable, .hid_detected, .load_above, .load_below, .wake_load_above,
    .wake_load_below, .primary_detect, .data_switch_on, .discharge_on, .current_limit,
    .load_status_n, .charge_mode, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);

  portable_device #(.LOW_LIMIT_MA(LO_MA), .WAKE_ABOVE_MA(WAKE_MA),
    .WAKE_BELOW_MA(WAKE_LO_MA)) i_partner (
    .clk, .arst_n, .draw_ma, .hid_attach, .primary_req, .data_switch_on, .hid_detected,
    .load_above, .load_below, .wake_load_above, .wake_load_below, .primary_detect);

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic drive(input logic [3:0] c, input logic en, input int d);
    {mode_select_a, mode_select_b, mode_select_c, limit_select} <= c;
    enable <= en;
    draw_ma <= d[15:0];
  endtask : drive

  function automatic void model(input logic [3:0] c, input int d, output int m,
                                output int lim, output int st);
    m = mt[c];
    lim = lt[c];
    st = (m == 3 || m == 8) ? int'(d <= LO_MA + 60) : (m == 2) ? int'(d <= WAKE_MA) : 1;
    if (m == 2 && st == 0)
      lim = 2;
  endfunction : model

  task automatic check_all(input logic [3:0] c, input logic en, input int d);
    int m, lim, st;
    model(c, d, m, lim, st);
    chk("charge_mode", m, charge_mode);
    chk("current_limit", lim, current_limit);
    chk("data_switch_on", en && m >= 6, data_switch_on);
    chk("discharge_on", m == 0, discharge_on);
    chk("load_status_n", st, load_status_n);
  endtask : check_all

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // idle edge so a following call never re-drives psel in this time step
    @(posedge clk);
    if (n >= 50)
      fails++;
  endtask : apb

  task automatic count_dis(input int n, output int w);
    w = 0;
    repeat (n)
    begin
      @(posedge clk);
      w += int'(discharge_on === 1'h1);
    end
  endtask : count_dis

  task automatic report_and_stop();
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // the switch must never be closed while the output discharges
  always @(posedge clk)
  begin
    if (arst_n && discharge_on === 1'h1)
      chk("switch_in_discharge", 0, data_switch_on);
  end

  initial
  begin
    logic [31:0] rd;
    logic er, en;
    logic [3:0] c;
    int w, d;
    cyc(20);
    chk("reset_mode", 0, charge_mode);
    chk("reset_discharge", 1, discharge_on);
    chk("reset_switch", 0, data_switch_on);
    arst_n <= 1'h1;
    cyc(1);
    apb(1'h0, DISCHARGE_LEN_ADDR, 32'h0, rd, er);
    chk("len_reset", 32'h0000_0400, rd);
    apb(1'h1, DISCHARGE_LEN_ADDR, 32'hFFFF_0008, rd, er);
    apb(1'h0, DISCHARGE_LEN_ADDR, 32'h0, rd, er);
    chk("len", DLEN, rd);
    apb(1'h0, 8'h08, 32'h0, rd, er);
    chk("unmapped_err", 1, er);
    chk("unmapped_data", 0, rd);
    apb(1'h1, STATUS_ADDR, 32'hFFFF_FFFF, rd, er);
    chk("ro_write_err", 0, er);
    // every code once, then random codes, enables and loads
    for (int i = 0; i < 40; i++)
    begin
      c = (i < 16) ? 4'(i) : 4'($random(seed));
      en = (i < 16) ? 1'h1 : 1'($random(seed));
      d = draws[$unsigned($random(seed)) % 2];
      drive(c, en, d);
      cyc(70);
      check_all(c, en, d);
    end
    drive(4'hF, 1'h1, 1200);
    cyc(70);
    apb(1'h0, STATUS_ADDR, 32'h0, rd, er);
    chk("status_reg", 32'h0000_0528, rd);
    drive(4'hE, 1'h1, 1200);
    count_dis(70, w);
    chk("no_discharge_down", 0, w);
    check_all(4'hE, 1'h1, 1200);
    drive(4'hF, 1'h1, 1200);
    count_dis(70, w);
    chk("no_discharge_cycles", 0, w);
    drive(4'h2, 1'h1, 100);
    cyc(70);
    drive(4'hF, 1'h1, 100);
    count_dis(40, w);
    chk("discharge_cycles", DLEN, w);
    cyc(30);
    check_all(4'hF, 1'h1, 100);
    drive(4'h2, 1'h1, 800);
    cyc(70);
    drive(4'h3, 1'h1, 800);
    cyc(70);
    check_all(4'h3, 1'h1, 800);
    drive(4'h7, 1'h1, 800);
    cyc(70);
    check_all(4'h7, 1'h1, 800);
    drive(4'h3, 1'h1, 1200);
    cyc(70);
    check_all(4'h3, 1'h1, 1200);
    // a load between both thresholds keeps the release timer idle
    drive(4'hE, 1'h1, 530);
    cyc(70);
    drive(4'hF, 1'h1, 530);
    cyc(70);
    chk("status_before_primary", 1, load_status_n);
    primary_req <= 1'h1;
    cyc(1);
    primary_req <= 1'h0;
    cyc(3);
    chk("status_after_primary", 0, load_status_n);
    hid_attach <= 1'h1;
    cyc(3);
    drive(4'h4, 1'h1, 100);
    cyc(70);
    chk("held_mode", 8, charge_mode);
    chk("held_limit", 2, current_limit);
    hid_attach <= 1'h0;
    cyc(70);
    check_all(4'h4, 1'h1, 100);
    report_and_stop();
  end

  initial
  begin
    #200000;
    fails++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
